// ---- hw/fllmf_pkg.sv ----
// Register map, field layout and constants of the loop clock control block
`default_nettype none
package fllmf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FACTOR_W = 11;
  localparam int TRIM_W = 9;
  localparam int LOCK_TOLERANCE = 4;

  // ***************************************
  // Register offsets
  // ***************************************
  localparam logic [7:0] OFS_CLOCK_CONTROL_ZERO = 8'h34;
  localparam logic [7:0] OFS_CLOCK_CONTROL_ONE = 8'h35;
  localparam logic [7:0] OFS_LOOP_MULTIPLIER = 8'h36;
  localparam logic [7:0] OFS_CLOCK_FLAGS = 8'h37;
  localparam logic [7:0] OFS_REFERENCE_TRIM_HIGH = 8'h38;
  localparam logic [7:0] OFS_REFERENCE_TRIM_LOW = 8'h39;
  localparam logic [7:0] OFS_FACTORY_TEST_ZERO = 8'h3a;

  // ***************************************
  // Field positions
  // ***************************************
  localparam int CZ_OSC_ENABLE = 7;
  localparam int CZ_DIVIDER_HI = 6;
  localparam int CZ_DIVIDER_LO = 4;
  localparam int CZ_BUS_CLOCK_SELECT = 3;
  localparam int CZ_REFERENCE_SELECT = 2;
  localparam int CZ_OSC_FILTER_LOW = 1;
  localparam int CO_BUS_DIVIDER_HI = 7;
  localparam int CO_BUS_DIVIDER_LO = 4;
  localparam int CO_LOCK_IRQ_ENABLE = 1;
  localparam int FL_POWER_ON = 6;
  localparam int FL_LOCK_CHANGE = 4;
  localparam int FL_LOCK_STATUS = 3;
  localparam int FL_ILLEGAL_ACCESS = 2;
  localparam int FL_OSC_STARTED = 1;
  localparam int TRIM_HIGH_BIT = 8;

  // ***************************************
  // Reset values and fixed figures
  // ***************************************
  localparam logic [FACTOR_W-1:0] LOOP_FACTOR_BASE = 11'h3e8;
  localparam logic [6:0] LOOP_MULTIPLIER_RESET = 7'h00;
  localparam logic [2:0] DIVIDER_RESET = 3'h0;
  localparam logic [3:0] BUS_DIVIDER_RESET = 4'h0;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 9'h000;
  localparam logic [7:0] FACTORY_TEST_ZERO_VALUE = 8'h00;

  // Oscillator division ratio per divider code; the reserved code keeps 512
  function automatic logic [9:0] ref_ratio(input logic [2:0] code);
    case (code)
      3'h0: ref_ratio = 10'h080;
      3'h1: ref_ratio = 10'h0a0;
      3'h2: ref_ratio = 10'h0c0;
      3'h3: ref_ratio = 10'h100;
      3'h4: ref_ratio = 10'h140;
      3'h5: ref_ratio = 10'h180;
      default: ref_ratio = 10'h200;
    endcase
  endfunction
endpackage
`default_nettype wire

// ---- hw/fllmf_meter_if.sv ----
// Interface between the register side and the lock meter
`timescale 1ns/1ns
`default_nettype none
interface fllmf_meter_if import fllmf_pkg::*; ();
  logic ref_tick;
  logic dco_tick;
  logic restart;
  logic [FACTOR_W-1:0] factor;
  logic in_lock;
  logic dco_slow;
  logic dco_fast;
  modport ctrl (output ref_tick, dco_tick, restart, factor, input in_lock, dco_slow, dco_fast);
  modport meter (input ref_tick, dco_tick, restart, factor, output in_lock, dco_slow, dco_fast);
endinterface
`default_nettype wire

// ---- hw/fllmf_lock_meter.sv ----
// Lock meter: counts oscillator ticks per reference period against the factor
`timescale 1ns/1ns
`default_nettype none
module fllmf_lock_meter import fllmf_pkg::*; #(
  parameter int LOCK_TOL = LOCK_TOLERANCE,
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Loop side
  fllmf_meter_if.meter m
);
  if (LOCK_TOL < 1 || LOCK_TOL > 64 || CNT_W < FACTOR_W + 1) begin : g_bad
    $error("fllmf_lock_meter: unsupported parameters");
  end

  logic [CNT_W-1:0] count_q;
  logic armed_q;
  logic in_lock_q;
  logic slow_q;
  logic fast_q;
  logic [CNT_W:0] cnt_lo;
  logic [CNT_W:0] cnt_hi;
  logic eval;

  assign cnt_lo = {1'b0, count_q} + (CNT_W+1)'(LOCK_TOL);
  assign cnt_hi = (CNT_W+1)'(m.factor) + (CNT_W+1)'(LOCK_TOL);
  assign eval = m.ref_tick && armed_q;

  // ***************************************
  // Tick counter over one reference period
  // ***************************************
  always_ff @(posedge ref_clk) begin
    if (srst || m.restart) begin
      count_q <= '0;
    end else if (m.ref_tick) begin
      count_q <= CNT_W'(m.dco_tick);
    end else if (m.dco_tick && !(&count_q)) begin
      count_q <= count_q + 1'b1;
    end
  end

  // A window only counts once it started after the last restart
  always_ff @(posedge ref_clk) begin
    if (srst || m.restart) begin
      armed_q <= 1'b0;
    end else if (m.ref_tick) begin
      armed_q <= 1'b1;
    end
  end

  // ***************************************
  // Comparison against the factor
  // ***************************************
  always_ff @(posedge ref_clk) begin
    if (srst || m.restart) begin
      in_lock_q <= 1'b0;
      slow_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      if (eval) begin
        in_lock_q <= (cnt_lo >= (CNT_W+1)'(m.factor)) && ({1'b0, count_q} <= cnt_hi);
      end
      slow_q <= eval && (cnt_lo < (CNT_W+1)'(m.factor));
      fast_q <= eval && ({1'b0, count_q} > cnt_hi);
    end
  end

  assign m.in_lock = in_lock_q;
  assign m.dco_slow = slow_q;
  assign m.dco_fast = fast_q;

  // ***************************************
  // Checks
  // ***************************************
  restart_unlock_a: assert property (@(posedge ref_clk) disable iff (srst)
    m.restart |=> !in_lock_q) else $error("meter kept lock after restart");
  steer_excl_a: assert property (@(posedge ref_clk) disable iff (srst)
    !(slow_q && fast_q) && !((slow_q || fast_q) && in_lock_q))
    else $error("meter steering conflict");
endmodule // fllmf_lock_meter
`default_nettype wire

// ---- hw/fllmf_clock_ctrl.sv ----
// Register side of the frequency-locked-loop clock generator
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module fllmf_clock_ctrl import fllmf_pkg::*; #(
  parameter int LOCK_TOL = LOCK_TOLERANCE
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic por,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  // System events
  input wire logic stop_entry,
  input wire logic illegal_access,
  // Oscillator ready level and clock sources as one-cycle ticks
  input wire logic osc_ready,
  input wire logic osc_tick,
  input wire logic irc_tick,
  input wire logic dco_tick,
  // Factory trim from nonvolatile memory
  input wire logic [TRIM_W-1:0] factory_trim,
  // Analog controls
  output logic [FACTOR_W-1:0] loop_factor,
  output logic [TRIM_W-1:0] ref_trim,
  output logic osc_enable,
  output logic osc_filter_low,
  output logic bus_clock_select,
  output logic [3:0] bus_divider,
  output logic osc_monitor_enable,
  output logic dco_slow,
  output logic dco_fast,
  // Interrupt request
  output logic lock_irq
);
  if (LOCK_TOL < 1 || LOCK_TOL > 64) begin : g_bad
    $error("fllmf_clock_ctrl: unsupported lock tolerance");
  end

  fllmf_meter_if mif ();

  logic osc_enable_q;
  logic [2:0] reference_divider_q;
  logic bus_clock_select_q;
  logic reference_select_q;
  logic osc_filter_q;
  logic [3:0] bus_divider_q;
  logic lock_irq_enable_q;
  logic [6:0] loop_multiplier_q;
  logic [TRIM_W-1:0] trim_q;
  logic power_on_flag_q;
  logic illegal_flag_q;
  logic lock_change_flag_q;
  logic lock_status_q;
  logic osc_started_q;
  logic reset_seen_q;
  logic [9:0] div_cnt_q;
  logic osc_div_tick_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] flags_view;
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_mul;
  logic wr_flg;
  logic wr_trh;
  logic wr_trl;
  logic lock_clear;
  logic osc_off;
  logic trim_load;
  logic any_reset;

  // ***************************************
  // Write decode
  // ***************************************
  assign wr_ctl0 = wr_en && (addr == OFS_CLOCK_CONTROL_ZERO);
  assign wr_ctl1 = wr_en && (addr == OFS_CLOCK_CONTROL_ONE);
  assign wr_mul = wr_en && (addr == OFS_LOOP_MULTIPLIER);
  assign wr_flg = wr_en && (addr == OFS_CLOCK_FLAGS);
  assign wr_trh = wr_en && (addr == OFS_REFERENCE_TRIM_HIGH);
  assign wr_trl = wr_en && (addr == OFS_REFERENCE_TRIM_LOW);
  assign any_reset = srst || por;
  assign lock_clear = stop_entry || wr_ctl0 || wr_mul || wr_trh || wr_trl;
  assign osc_off = stop_entry || !osc_enable_q || (wr_ctl0 && !wdata[CZ_OSC_ENABLE]);
  assign trim_load = reset_seen_q && !any_reset;

  // ***************************************
  // Control registers
  // ***************************************
  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      osc_enable_q <= 1'b0;
      reference_divider_q <= DIVIDER_RESET;
      osc_filter_q <= 1'b0;
    end else if (wr_ctl0) begin
      osc_enable_q <= wdata[CZ_OSC_ENABLE];
      reference_divider_q <= wdata[CZ_DIVIDER_HI:CZ_DIVIDER_LO];
      if (!osc_enable_q) begin
        osc_filter_q <= wdata[CZ_OSC_FILTER_LOW];
      end
    end
  end

  // Oscillator selections need a started oscillator and fall with it
  always_ff @(posedge ref_clk) begin
    if (any_reset || osc_off) begin
      bus_clock_select_q <= 1'b0;
      reference_select_q <= 1'b0;
    end else if (wr_ctl0) begin
      bus_clock_select_q <= wdata[CZ_BUS_CLOCK_SELECT] && osc_started_q;
      reference_select_q <= wdata[CZ_REFERENCE_SELECT] && osc_started_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      bus_divider_q <= BUS_DIVIDER_RESET;
      lock_irq_enable_q <= 1'b0;
    end else if (wr_ctl1) begin
      bus_divider_q <= wdata[CO_BUS_DIVIDER_HI:CO_BUS_DIVIDER_LO];
      lock_irq_enable_q <= wdata[CO_LOCK_IRQ_ENABLE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      loop_multiplier_q <= LOOP_MULTIPLIER_RESET;
    end else if (wr_mul) begin
      loop_multiplier_q <= wdata[6:0];
    end
  end

  // ***************************************
  // Trim: factory value on reset release
  // ***************************************
  always_ff @(posedge ref_clk) begin
    reset_seen_q <= any_reset;
  end

  // Smaller trim speeds the internal reference up, larger slows it
  always_ff @(posedge ref_clk) begin
    if (por) begin
      trim_q <= TRIM_RESET;
    end else if (trim_load) begin
      trim_q <= factory_trim;
    end else if (!srst) begin
      if (wr_trh) begin
        trim_q[TRIM_HIGH_BIT] <= wdata[0];
      end
      if (wr_trl) begin
        trim_q[TRIM_HIGH_BIT-1:0] <= wdata;
      end
    end
  end

  // ***************************************
  // Oscillator startup status
  // ***************************************
  always_ff @(posedge ref_clk) begin
    if (any_reset || osc_off) begin
      osc_started_q <= 1'b0;
    end else if (osc_ready) begin
      osc_started_q <= 1'b1;
    end
  end

  // ***************************************
  // Loop reference and lock tracking
  // ***************************************
  always_ff @(posedge ref_clk) begin
    if (any_reset || wr_ctl0) begin
      div_cnt_q <= '0;
      osc_div_tick_q <= 1'b0;
    end else begin
      osc_div_tick_q <= osc_tick && (div_cnt_q == ref_ratio(reference_divider_q) - 10'h001);
      if (osc_tick) begin
        if (div_cnt_q == ref_ratio(reference_divider_q) - 10'h001) begin
          div_cnt_q <= '0;
        end else begin
          div_cnt_q <= div_cnt_q + 10'h001;
        end
      end
    end
  end

  assign mif.ref_tick = reference_select_q ? osc_div_tick_q : irc_tick;
  assign mif.dco_tick = dco_tick;
  assign mif.restart = lock_clear || any_reset;
  assign mif.factor = LOOP_FACTOR_BASE + {3'h0, loop_multiplier_q, 1'b0};

  fllmf_lock_meter #(
    .LOCK_TOL(LOCK_TOL),
    .CNT_W(FACTOR_W + 1)
  ) u_meter (
    .ref_clk(ref_clk),
    .srst(srst),
    .m(mif.meter)
  );

  // Forced clears follow the meter silently, measured changes raise the flag
  always_ff @(posedge ref_clk) begin
    if (any_reset || lock_clear) begin
      lock_status_q <= 1'b0;
    end else begin
      lock_status_q <= mif.in_lock;
    end
  end

  // ***************************************
  // Flags: only power-on resets them
  // ***************************************
  always_ff @(posedge ref_clk) begin
    if (por) begin
      power_on_flag_q <= 1'b1;
    end else if (wr_flg && wdata[FL_POWER_ON]) begin
      power_on_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (illegal_access) begin
      illegal_flag_q <= 1'b1;
    end else if (por || (wr_flg && wdata[FL_ILLEGAL_ACCESS])) begin
      illegal_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (por) begin
      lock_change_flag_q <= 1'b0;
    end else if (!srst && !lock_clear && (mif.in_lock != lock_status_q)) begin
      lock_change_flag_q <= 1'b1;
    end else if (wr_flg && wdata[FL_LOCK_CHANGE]) begin
      lock_change_flag_q <= 1'b0;
    end
  end

  // ***************************************
  // Read port
  // ***************************************
  always_comb begin
    flags_view = '0;
    flags_view[FL_POWER_ON] = power_on_flag_q;
    flags_view[FL_LOCK_CHANGE] = lock_change_flag_q;
    flags_view[FL_LOCK_STATUS] = lock_status_q;
    flags_view[FL_ILLEGAL_ACCESS] = illegal_flag_q;
    flags_view[FL_OSC_STARTED] = osc_started_q;
  end

  always_ff @(posedge ref_clk) begin
    if (any_reset || !rd_en) begin
      rdata_q <= '0;
    end else begin
      case (addr)
        OFS_CLOCK_CONTROL_ZERO: rdata_q <= {osc_enable_q, reference_divider_q, bus_clock_select_q,
          reference_select_q, osc_filter_q, 1'b0};
        OFS_CLOCK_CONTROL_ONE: rdata_q <= {bus_divider_q, 2'h0, lock_irq_enable_q, 1'b0};
        OFS_LOOP_MULTIPLIER: rdata_q <= {1'b0, loop_multiplier_q};
        OFS_CLOCK_FLAGS: rdata_q <= flags_view;
        OFS_REFERENCE_TRIM_HIGH: rdata_q <= {7'h00, trim_q[TRIM_HIGH_BIT]};
        OFS_REFERENCE_TRIM_LOW: rdata_q <= trim_q[TRIM_HIGH_BIT-1:0];
        OFS_FACTORY_TEST_ZERO: rdata_q <= FACTORY_TEST_ZERO_VALUE;
        default: rdata_q <= '0;
      endcase
    end
  end

  // ***************************************
  // Outputs
  // ***************************************
  assign rdata = rdata_q;
  assign loop_factor = mif.factor;
  assign ref_trim = trim_q;
  assign osc_enable = osc_enable_q;
  assign osc_filter_low = osc_filter_q;
  assign bus_clock_select = bus_clock_select_q;
  assign bus_divider = bus_divider_q;
  assign osc_monitor_enable = osc_enable_q && osc_started_q;
  assign dco_slow = mif.dco_slow;
  assign dco_fast = mif.dco_fast;
  assign lock_irq = lock_change_flag_q && lock_irq_enable_q;

  // ***************************************
  // Checks
  // ***************************************
  default clocking cb @(posedge ref_clk); endclocking

  factor_write_a: assert property (disable iff (srst)
    wr_mul |=> loop_factor == LOOP_FACTOR_BASE + 11'($past(wdata[6:0])) * 11'h002)
    else $error("loop factor does not follow multiplier write");
  por_flag_a: assert property (disable iff (1'b0)
    por |=> power_on_flag_q ##1 (power_on_flag_q || $past(wr_flg)))
    else $error("power-on flag not set or lost");
  por_keep_a: assert property (disable iff (por)
    srst [*2] |-> $stable(power_on_flag_q)) else $error("power-on flag moved in reset");
  illegal_set_a: assert property (disable iff (por)
    illegal_access |=> illegal_flag_q) else $error("illegal access not flagged");
  illegal_por_a: assert property (disable iff (1'b0)
    por && !illegal_access |=> !illegal_flag_q) else $error("illegal flag kept by power-on");
  lock_change_a: assert property (disable iff (any_reset)
    $changed(lock_status_q) && !$past(lock_clear) && !$past(any_reset) |-> lock_change_flag_q)
    else $error("lock change not flagged");
  irq_gate_a: assert property (disable iff (srst)
    lock_irq |-> lock_change_flag_q && lock_irq_enable_q) else $error("stray lock interrupt");
  silent_clear_a: assert property (disable iff (any_reset)
    lock_clear && lock_status_q && !lock_change_flag_q && !wr_flg |=> !lock_status_q
    && !lock_change_flag_q) else $error("forced unlock misbehaved");
  sel_gate_a: assert property (disable iff (srst)
    wr_ctl0 && !osc_started_q |=> !reference_select_q && !bus_clock_select_q)
    else $error("oscillator selected before startup");
  osc_stop_a: assert property (disable iff (srst)
    stop_entry |=> !osc_started_q && !osc_monitor_enable) else $error("startup kept in stop");
  trim_load_a: assert property (disable iff (por)
    $fell(srst) |=> ref_trim == $past(factory_trim)) else $error("factory trim not loaded");
  test_read_a: assert property (disable iff (srst)
    rd_en && addr == OFS_FACTORY_TEST_ZERO |=> rdata == FACTORY_TEST_ZERO_VALUE)
    else $error("test register read wrong");

  lock_gain_c: cover property (disable iff (srst) $rose(lock_status_q));
  irq_c: cover property (disable iff (srst) $rose(lock_irq));
  osc_ref_c: cover property (disable iff (srst) $rose(reference_select_q));
  flag_clear_c: cover property (disable iff (srst) $fell(power_on_flag_q));
endmodule // fllmf_clock_ctrl
`default_nettype wire

// ---- verification/fll_multiply_flags_trim_tb.sv ----
// Self-checking testbench for the loop clock control block
`timescale 1ns/1ns
`default_nettype none
module fll_multiply_flags_trim_tb import fllmf_pkg::*;;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} fllmf_row_s;
  logic ref_clk, srst, por, wr_en, rd_en, stop_entry, illegal_access;
  logic osc_ready, osc_tick, irc_tick, dco_tick, irc_run;
  logic [7:0] addr, wdata, rdata, d;
  logic [8:0] factory_trim, ref_trim;
  logic [10:0] loop_factor;
  logic osc_enable, osc_filter_low, bus_clock_select, osc_monitor_enable;
  logic dco_slow, dco_fast, lock_irq;
  logic seen_slow = 1'b0;
  logic seen_fast = 1'b0;
  logic [3:0] bus_divider;
  int fail_count = 0;
  int n_checks = 0;
  int irc_cnt = 0;
  fllmf_row_s rows [9] = '{'{8'h36, 8'hff, 8'h7f}, '{8'h36, 8'h05, 8'h05},
    '{8'h38, 8'hff, 8'h01}, '{8'h39, 8'ha5, 8'ha5}, '{8'h3a, 8'hff, 8'h00},
    '{8'h3b, 8'hff, 8'h00}, '{8'h37, 8'hab, 8'h40}, '{8'h34, 8'h0e, 8'h02},
    '{8'h35, 8'hf2, 8'hf2}};

  fllmf_clock_ctrl fllmf_clock_ctrl_i (.ref_clk(ref_clk), .srst(srst), .por(por),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .stop_entry(stop_entry), .illegal_access(illegal_access), .osc_ready(osc_ready),
    .osc_tick(osc_tick), .irc_tick(irc_tick), .dco_tick(dco_tick),
    .factory_trim(factory_trim), .loop_factor(loop_factor), .ref_trim(ref_trim),
    .osc_enable(osc_enable), .osc_filter_low(osc_filter_low),
    .bus_clock_select(bus_clock_select), .bus_divider(bus_divider),
    .osc_monitor_enable(osc_monitor_enable), .dco_slow(dco_slow), .dco_fast(dco_fast),
    .lock_irq(lock_irq));

  // ***************************************
  // Clock, reference ticks and bus tasks
  // ***************************************
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Internal reference tick every 1000 cycles, matching factor 1000 with dco every cycle
  always @(posedge ref_clk) begin
    irc_cnt <= (irc_cnt == 999) ? 0 : irc_cnt + 1;
    irc_tick <= irc_run && (irc_cnt == 999);
  end

  // Sticky record of the steering pulses
  always @(posedge ref_clk) begin
    if (dco_slow === 1'b1) seen_slow <= 1'b1;
    if (dco_fast === 1'b1) seen_fast <= 1'b1;
  end

  task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, v, e);
  endtask

  task automatic pulse_reset(input bit power);
    @(posedge ref_clk);
    srst <= 1'b1;
    por <= power;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    por <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pulse_illegal();
    @(posedge ref_clk);
    illegal_access <= 1'b1;
    @(posedge ref_clk);
    illegal_access <= 1'b0;
  endtask

  // Polls the flags until the lock status bit reaches the wanted value
  task automatic wait_lock(input logic want);
    for (int i = 0; i < 1500; i++) begin
      rd(8'h37, d);
      if (d[3] === want) break;
    end
  endtask

  task automatic results();
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    results();
  end

  // ***************************************
  // Main sequence
  // ***************************************
  initial begin
    {srst, por} = 2'b11;
    {wr_en, rd_en, stop_entry, illegal_access} = '0;
    {osc_ready, osc_tick, dco_tick, irc_run} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    factory_trim = 9'h15a;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    por <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rchk(8'h37, 8'h40, "flags after power on");
    chk("trim after power on", ref_trim, 9'h15a);
    chk("factor after reset", loop_factor, 11'h3e8);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e, "register row");
    end
    chk("filter stored", osc_filter_low, 1'b1);
    chk("bus divider", bus_divider, 4'hf);
    chk("trim pair", ref_trim, 9'h1a5);
    chk("factor five", loop_factor, 11'h3f2);
    wr(8'h36, 8'h7f);
    #1 chk("factor max", loop_factor, 11'h4e6);
    wr(8'h35, 8'h00);
    pulse_illegal();
    rchk(8'h37, 8'h44, "illegal set");
    wr(8'h37, 8'h04);
    rchk(8'h37, 8'h40, "illegal cleared");
    pulse_illegal();
    factory_trim <= 9'h0c3;
    pulse_reset(1'b0);
    rchk(8'h37, 8'h44, "flags kept on system reset");
    chk("trim reload", ref_trim, 9'h0c3);
    chk("factor after system reset", loop_factor, 11'd1000);
    pulse_reset(1'b1);
    rchk(8'h37, 8'h40, "flags after second power on");
    wr(8'h37, 8'h40);
    rchk(8'h37, 8'h00, "power flag cleared");
    wr(8'h34, 8'h80);
    osc_ready <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rchk(8'h37, 8'h02, "osc started");
    chk("monitor on", osc_monitor_enable, 1'b1);
    chk("osc enable", osc_enable, 1'b1);
    wr(8'h34, 8'h8e);
    rchk(8'h34, 8'h8c, "selects accepted");
    chk("bus select on", bus_clock_select, 1'b1);
    chk("filter refused", osc_filter_low, 1'b0);
    @(posedge ref_clk);
    osc_ready <= 1'b0;
    stop_entry <= 1'b1;
    @(posedge ref_clk);
    stop_entry <= 1'b0;
    rchk(8'h37, 8'h00, "osc started after stop");
    chk("bus select after stop", bus_clock_select, 1'b0);
    chk("monitor off", osc_monitor_enable, 1'b0);
    wr(8'h34, 8'h00);
    wr(8'h35, 8'h02);
    dco_tick <= 1'b1;
    irc_run <= 1'b1;
    wait_lock(1'b1);
    chk("lock and change", d & 8'h18, 8'h18);
    chk("irq raised", lock_irq, 1'b1);
    wr(8'h37, 8'h10);
    #1 chk("irq after clear", lock_irq, 1'b0);
    rchk(8'h37, 8'h08, "change cleared");
    wr(8'h36, 8'h00);
    rchk(8'h37, 8'h00, "silent unlock");
    wait_lock(1'b1);
    wr(8'h35, 8'h00);
    rchk(8'h37, 8'h18, "relocked");
    chk("irq masked", lock_irq, 1'b0);
    chk("no slow while locked", seen_slow, 1'b0);
    wr(8'h37, 8'h10);
    dco_tick <= 1'b0;
    wait_lock(1'b0);
    chk("unlock change", d & 8'h18, 8'h10);
    chk("slow seen", seen_slow, 1'b1);
    chk("fast not seen", seen_fast, 1'b0);
    results();
  end
endmodule // fll_multiply_flags_trim_tb
`default_nettype wire
